// ==== rtl/panel_defs.svh ====
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH

// ==========================================================
// Timing
`define CLK_HZ 200000000
`define LONG_PRESS_MS 1000
`define FLASH_MS 1000
`define REPEAT_DELAY_MS 500
`define REPEAT_RATE_MS 50
`define DEBOUNCE_US 5000
`define BLINK_MS 250
// ==========================================================
// Codes and values
`define JOG_FN_CODE 12'h002
`define JOG_SPEED_RESET 17'h001F4
`define PARAM_MAX 12'h999
`define DIGIT_MAX_5 3'h4
`define DIGIT_MAX_3 3'h2
`define JOG_PARAM_NUM 12'h304

`endif

// ==== rtl/panel_pkg.sv ====
package panel_pkg;

  typedef enum logic [2:0] {
    MODE_STATUS = 3'h0,
    MODE_SYSCHK = 3'h1,
    MODE_JOG = 3'h5,
    MODE_PNUM = 3'h3,
    MODE_PSET = 3'h7,
    MODE_MON = 3'h2
  } mode_t;

  typedef struct packed {
    logic up;
    logic down;
    logic right;
    logic modeset;
    logic data;
  } keys_t;

  typedef struct packed {
    logic energize;
    logic fwd;
    logic rev;
    logic [16:0] speed;
  } motor_cmd_t;

  typedef struct packed {
    mode_t mode;
    logic [11:0] number;
    logic [16:0] value;
    logic [2:0] digit;
    logic [4:0] blank_digits;
    logic save_flash;
    logic jog_active;
  } panel_view_t;

endpackage : panel_pkg

// ==== rtl/keypad_jog_and_parameter_editor.sv ====
`include "panel_defs.svh"

module keypad_jog_and_parameter_editor
  import panel_pkg::*;
#(
  parameter int LONG_CYC = (`CLK_HZ / 1000) * `LONG_PRESS_MS,
  parameter int FLASH_CYC = (`CLK_HZ / 1000) * `FLASH_MS,
  parameter int RPT_DLY_CYC = (`CLK_HZ / 1000) * `REPEAT_DELAY_MS,
  parameter int RPT_CYC = (`CLK_HZ / 1000) * `REPEAT_RATE_MS,
  parameter int DEB_CYC = (`CLK_HZ / 1000000) * `DEBOUNCE_US,
  parameter int BLINK_CYC = (`CLK_HZ / 1000) * `BLINK_MS
)(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire keys_t keys_i,
  input wire logic [1:0] status_bits_i,
  output keys_t dummy_unused_o,
  output motor_cmd_t motor_o,
  output panel_view_t view_o,
  output logic [1:0] status_bits_o,
  output logic [16:0] jog_speed_setting_o,
  output logic save_pulse_o
);

  // ========================================================
  // Digit helpers
  function automatic logic [3:0] get_dig(input logic [16:0] v, input logic [2:0] d);
    logic [16:0] t;
    t = v;
    for (int i = 0; i < 5; i++)
    begin
      if (3'(i) < d)
      begin
        t = 17'(t / 17'd10);
      end
    end
    return 4'(t % 17'd10);
  endfunction : get_dig

  function automatic logic [16:0] pow10(input logic [2:0] d);
    logic [16:0] p;
    p = 17'h00001;
    for (int i = 0; i < 4; i++)
    begin
      if (3'(i) < d)
      begin
        p = 17'(p * 17'd10);
      end
    end
    return p;
  endfunction : pow10

  // Step one decimal digit with wrap inside the digit
  function automatic logic [16:0] step_dig(input logic [16:0] v, input logic [2:0] d, input logic up);
    logic [3:0] c;
    logic [16:0] p;
    c = get_dig(v, d);
    p = pow10(d);
    if (up)
    begin
      return (c == 4'h9) ? 17'(v - 17'(p * 17'd9)) : 17'(v + p);
    end
    return (c == 4'h0) ? 17'(v + 17'(p * 17'd9)) : 17'(v - p);
  endfunction : step_dig

  // Step one BCD nibble of a three-digit number, wrapping inside the nibble
  function automatic logic [11:0] step_bcd(input logic [11:0] n, input logic [2:0] d, input logic up);
    logic [11:0] r;
    r = n;
    for (int i = 0; i < 3; i++)
    begin
      if (3'(i) == d)
      begin
        r[4*i +: 4] = up ? ((n[4*i +: 4] >= 4'h9) ? 4'h0 : 4'(n[4*i +: 4] + 4'h1))
                         : ((n[4*i +: 4] == 4'h0) ? 4'h9 : 4'(n[4*i +: 4] - 4'h1));
      end
    end
    return r;
  endfunction : step_bcd

  // Parameter numbers in use: x00..x15 in groups 0..6
  function automatic logic num_used(input logic [11:0] n);
    return (n[11:8] <= 4'h6) && (n[7:4] == 4'h0 || (n[7:4] == 4'h1 && n[3:0] <= 4'h5));
  endfunction : num_used

  // ========================================================
  // Debounce and press timing
  keys_t deb_ff, nxt_deb, prev_ff, nxt_prev;
  logic [31:0] deb_cnt_ff, nxt_deb_cnt;
  logic [31:0] press_ff, nxt_press;
  logic long_done_ff, nxt_long_done;
  logic [31:0] rpt_ff, nxt_rpt;
  logic ev_left, ev_data, ev_up, ev_down, ev_right, ev_mode;

  always_comb
  begin
    nxt_deb = deb_ff;
    nxt_deb_cnt = deb_cnt_ff;
    nxt_prev = deb_ff;
    nxt_press = press_ff;
    nxt_long_done = long_done_ff;
    nxt_rpt = rpt_ff;
    ev_left = 1'b0;
    ev_data = 1'b0;
    ev_up = 1'b0;
    ev_down = 1'b0;
    ev_right = deb_ff.right && !prev_ff.right;
    ev_mode = deb_ff.modeset && !prev_ff.modeset;
    if (keys_i != deb_ff)
    begin
      nxt_deb_cnt = deb_cnt_ff + 32'd1;
      if (deb_cnt_ff >= 32'(DEB_CYC))
      begin
        nxt_deb = keys_i;
        nxt_deb_cnt = 32'd0;
      end
    end
    else
    begin
      nxt_deb_cnt = 32'd0;
    end
    if (deb_ff.data)
    begin
      nxt_press = press_ff + 32'd1;
      if (!long_done_ff && press_ff >= 32'(LONG_CYC - 1))
      begin
        ev_data = 1'b1;
        nxt_long_done = 1'b1;
      end
    end
    else
    begin
      nxt_press = 32'd0;
      nxt_long_done = 1'b0;
      ev_left = prev_ff.data && !long_done_ff;
    end
    if (deb_ff.up ^ deb_ff.down)
    begin
      if ((deb_ff.up && !prev_ff.up) || (deb_ff.down && !prev_ff.down))
      begin
        nxt_rpt = 32'(RPT_DLY_CYC);
        ev_up = deb_ff.up;
        ev_down = deb_ff.down;
      end
      else if (rpt_ff == 32'd0)
      begin
        nxt_rpt = 32'(RPT_CYC);
        ev_up = deb_ff.up;
        ev_down = deb_ff.down;
      end
      else
      begin
        nxt_rpt = rpt_ff - 32'd1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      deb_ff <= '0;
      prev_ff <= '0;
      deb_cnt_ff <= 32'd0;
      press_ff <= 32'd0;
      long_done_ff <= 1'b0;
      rpt_ff <= 32'd0;
    end
    else
    begin
      deb_ff <= nxt_deb;
      prev_ff <= nxt_prev;
      deb_cnt_ff <= nxt_deb_cnt;
      press_ff <= nxt_press;
      long_done_ff <= nxt_long_done;
      rpt_ff <= nxt_rpt;
    end
  end

  // ========================================================
  // Mode, editor and jog
  mode_t mode_ff, nxt_mode;
  logic [11:0] fn_ff, nxt_fn, pn_ff, nxt_pn, un_ff, nxt_un;
  logic [16:0] edit_ff, nxt_edit, jog_spd_ff, nxt_jog_spd;
  logic [2:0] dig_ff, nxt_dig;
  logic dirty_ff, nxt_dirty, motor_ff, nxt_motor, save_ff, nxt_save;
  logic [31:0] flash_ff, nxt_flash, blink_ff, nxt_blink;
  logic blink_on_ff, nxt_blink_on;
  logic [11:0] pn_step;
  logic [2:0] dig_max;
  logic [16:0] stored_val;
  logic [4:0] blank;

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_fn = fn_ff;
    nxt_pn = pn_ff;
    nxt_un = un_ff;
    nxt_edit = edit_ff;
    nxt_jog_spd = jog_spd_ff;
    nxt_dig = dig_ff;
    nxt_dirty = dirty_ff;
    nxt_motor = motor_ff;
    nxt_save = 1'b0;
    nxt_flash = (flash_ff != 32'd0) ? flash_ff - 32'd1 : 32'd0;
    nxt_blink = (blink_ff == 32'd0) ? 32'(BLINK_CYC) : blink_ff - 32'd1;
    nxt_blink_on = (blink_ff == 32'd0) ? !blink_on_ff : blink_on_ff;
    dig_max = (mode_ff == MODE_PSET) ? `DIGIT_MAX_5 : `DIGIT_MAX_3;
    // Only the jog speed is stored here; other numbers show zero
    stored_val = (pn_ff == `JOG_PARAM_NUM) ? jog_spd_ff : 17'h00000;
    pn_step = pn_ff;
    if (ev_up || ev_down)
    begin
      pn_step = step_bcd(pn_ff, dig_ff, ev_up);
      for (int i = 0; i < 16; i++)
      begin
        if (!num_used(pn_step))
        begin
          pn_step = ev_up ? ((pn_step[11:8] >= 4'h6) ? 12'h000 : {4'(pn_step[11:8] + 4'h1), 8'h00})
                          : ((pn_step[7:0] > 8'h15) ? {pn_step[11:8], 8'h15}
                          : {4'(pn_step[11:8] - 4'h1), 8'h15});
        end
      end
    end
    if (ev_left)
    begin
      nxt_dig = (dig_ff >= dig_max) ? 3'h0 : dig_ff + 3'h1;
    end
    else if (ev_right)
    begin
      nxt_dig = (dig_ff == 3'h0) ? dig_max : dig_ff - 3'h1;
    end
    case (mode_ff)
      MODE_STATUS:
      begin
        if (ev_mode)
        begin
          nxt_mode = MODE_SYSCHK;
          nxt_dig = 3'h0;
        end
      end
      MODE_SYSCHK:
      begin
        if (ev_up || ev_down)
        begin
          nxt_fn = step_bcd(fn_ff, dig_ff, ev_up);
        end
        if (ev_mode)
        begin
          nxt_mode = MODE_PNUM;
          nxt_dig = 3'h0;
        end
        else if (ev_data && fn_ff == `JOG_FN_CODE)
        begin
          nxt_mode = MODE_JOG;
        end
      end
      MODE_JOG:
      begin
        if (ev_mode)
        begin
          nxt_motor = !motor_ff;
        end
        if (ev_data)
        begin
          nxt_mode = MODE_SYSCHK;
          nxt_motor = 1'b0;
        end
      end
      MODE_PNUM:
      begin
        if (ev_up || ev_down)
        begin
          nxt_pn = pn_step;
        end
        if (ev_mode)
        begin
          nxt_mode = MODE_MON;
          nxt_dig = 3'h0;
        end
        else if (ev_data)
        begin
          nxt_mode = MODE_PSET;
          nxt_edit = stored_val;
          nxt_dirty = 1'b0;
          nxt_dig = 3'h0;
        end
      end
      MODE_PSET:
      begin
        if (ev_up || ev_down)
        begin
          nxt_edit = step_dig(edit_ff, dig_ff, ev_up);
          nxt_dirty = 1'b1;
        end
        if (ev_data)
        begin
          if (dirty_ff)
          begin
            // A step in the same cycle keeps the setting marked as changed
            nxt_dirty = ev_up || ev_down;
            nxt_save = 1'b1;
            nxt_flash = 32'(FLASH_CYC);
            if (pn_ff == `JOG_PARAM_NUM)
            begin
              nxt_jog_spd = edit_ff;
            end
          end
          else if (flash_ff == 32'd0)
          begin
            nxt_mode = MODE_PNUM;
            nxt_dig = 3'h0;
          end
        end
      end
      MODE_MON:
      begin
        if (ev_up || ev_down)
        begin
          nxt_un = step_bcd(un_ff, dig_ff, ev_up);
        end
        if (ev_mode)
        begin
          nxt_mode = MODE_STATUS;
        end
      end
      default:
      begin
        nxt_mode = MODE_STATUS;
      end
    endcase
    // Flash the operation digit, or all digits during a save
    blank = 5'h00;
    if (flash_ff != 32'd0 && !blink_on_ff)
    begin
      blank = 5'h1F;
    end
    else if (!blink_on_ff && mode_ff != MODE_STATUS && mode_ff != MODE_JOG)
    begin
      blank = 5'(5'h01 << dig_ff);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mode_ff <= MODE_STATUS;
      fn_ff <= 12'h000;
      pn_ff <= 12'h000;
      un_ff <= 12'h000;
      edit_ff <= 17'h00000;
      jog_spd_ff <= `JOG_SPEED_RESET;
      dig_ff <= 3'h0;
      dirty_ff <= 1'b0;
      motor_ff <= 1'b0;
      save_ff <= 1'b0;
      flash_ff <= 32'd0;
      blink_ff <= 32'd0;
      blink_on_ff <= 1'b1;
      motor_o <= '0;
      view_o <= '0;
      status_bits_o <= 2'h0;
      dummy_unused_o <= '0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      fn_ff <= nxt_fn;
      pn_ff <= nxt_pn;
      un_ff <= nxt_un;
      edit_ff <= nxt_edit;
      jog_spd_ff <= nxt_jog_spd;
      dig_ff <= nxt_dig;
      dirty_ff <= nxt_dirty;
      motor_ff <= nxt_motor;
      save_ff <= nxt_save;
      flash_ff <= nxt_flash;
      blink_ff <= nxt_blink;
      blink_on_ff <= nxt_blink_on;
      motor_o.energize <= motor_ff;
      motor_o.fwd <= motor_ff && mode_ff == MODE_JOG && deb_ff.up && !deb_ff.down;
      motor_o.rev <= motor_ff && mode_ff == MODE_JOG && deb_ff.down && !deb_ff.up;
      motor_o.speed <= jog_spd_ff;
      view_o.mode <= mode_ff;
      view_o.number <= (mode_ff == MODE_PNUM || mode_ff == MODE_PSET) ? pn_ff
                       : (mode_ff == MODE_MON) ? un_ff : fn_ff;
      view_o.value <= edit_ff;
      view_o.digit <= dig_ff;
      view_o.blank_digits <= blank;
      view_o.save_flash <= flash_ff != 32'd0;
      view_o.jog_active <= mode_ff == MODE_JOG;
      status_bits_o <= status_bits_i;
      dummy_unused_o <= deb_ff;
    end
  end

  assign jog_speed_setting_o = jog_spd_ff;
  assign save_pulse_o = save_ff;

endmodule : keypad_jog_and_parameter_editor

// ==== verif/panel_checker.sv ====
module panel_checker
  import panel_pkg::*;
#(
  parameter int FLASH_CYC = 20
)(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] status_bits_i,
  input wire motor_cmd_t motor_o,
  input wire panel_view_t view_o,
  input wire logic [1:0] status_bits_o,
  input wire logic [16:0] jog_speed_setting_o,
  input wire logic save_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ==========================================================
  // Flash length counter
  logic [31:0] flash_len_ff;
  logic [31:0] nxt_flash_len;

  always_comb
  begin
    nxt_flash_len = view_o.save_flash ? flash_len_ff + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk_i)
  begin
    flash_len_ff <= srst_i ? 32'h0 : nxt_flash_len;
  end

  // ==========================================================
  // Properties
  sequence jog_leave;
    $fell(view_o.jog_active);
  endsequence

  AST_RESET: assert property ($fell(srst_i) |-> view_o.mode == MODE_STATUS && !motor_o.energize
    && view_o.digit == 3'h0 && jog_speed_setting_o == 17'h001F4) else $error("reset state wrong");
  AST_FWD: assert property (motor_o.fwd |-> motor_o.energize && view_o.jog_active && !motor_o.rev)
    else $error("forward without energized jog");
  AST_REV: assert property (motor_o.rev |-> motor_o.energize && view_o.jog_active)
    else $error("reverse without energized jog");
  AST_SPEED: assert property ((motor_o.fwd || motor_o.rev) |-> motor_o.speed == jog_speed_setting_o)
    else $error("jog speed differs from setting");
  AST_STATUS: assert property (view_o.jog_active |-> status_bits_o == $past(status_bits_i))
    else $error("status bits not shown in jog");
  AST_JOG_EXIT: assert property (jog_leave |-> view_o.mode == MODE_SYSCHK)
    else $error("jog exit not to function code");
  AST_JOG_OFF: assert property (jog_leave |-> ##[0:2] !motor_o.energize)
    else $error("motor left on after jog");
  AST_DIGIT: assert property (view_o.mode inside {MODE_SYSCHK, MODE_PNUM, MODE_MON} |-> view_o.digit <= 3'h2)
    else $error("digit beyond three editable");
  AST_FLASH: assert property ($fell(view_o.save_flash) |-> flash_len_ff == FLASH_CYC)
    else $error("save flash length wrong");
  AST_PULSE: assert property (save_pulse_o |=> !save_pulse_o ##[0:1] view_o.save_flash)
    else $error("save pulse malformed");
  AST_BLINK: assert property ((view_o.mode == MODE_PNUM && !view_o.save_flash && view_o.blank_digits != 5'h00)
    |-> view_o.blank_digits == 5'(5'h01 << view_o.digit)) else $error("wrong digit flashing");
  AST_FLASH_ALL: assert property ((view_o.save_flash && view_o.blank_digits != 5'h00)
    |-> view_o.blank_digits == 5'h1F) else $error("save flash not on all digits");
endmodule : panel_checker

bind keypad_jog_and_parameter_editor panel_checker #(.FLASH_CYC(FLASH_CYC)) panel_checker_i (
  .clk_i(clk_i), .srst_i(srst_i), .status_bits_i(status_bits_i), .motor_o(motor_o), .view_o(view_o),
  .status_bits_o(status_bits_o), .jog_speed_setting_o(jog_speed_setting_o), .save_pulse_o(save_pulse_o));

// ==== verif/operator_model.sv ====
module operator_model
  import panel_pkg::*;
(
  input wire keys_t want_i,
  output keys_t keys_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // An operator never holds up and down together
  assign keys_o = (want_i.up && want_i.down) ? '0 : want_i;
endmodule : operator_model

// ==== verif/keypad_jog_and_parameter_editor_test.sv ====
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module keypad_jog_and_parameter_editor_test;
  import panel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = 20;
  typedef struct {int id; logic [16:0] val;} note_t;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  keys_t want = '0;
  keys_t keys_i;
  logic [1:0] status_bits_i = 2'h0;
  motor_cmd_t motor_o;
  panel_view_t view_o;
  logic [1:0] status_bits_o;
  logic [16:0] jog_speed_setting_o;
  logic save_pulse_o;
  int err_count = 0;
  int checked = 0;
  note_t exp_q[$];
  note_t n;
  event chk_ev;
  string nm [9] = '{"mode", "number", "value", "digit", "energize", "fwd", "rev", "speed", "jog_speed"};

  always #2.5 clk_i = ~clk_i;

  operator_model operator_model_i (.want_i(want), .keys_o(keys_i));

  keypad_jog_and_parameter_editor #(.LONG_CYC(L), .FLASH_CYC(20), .RPT_DLY_CYC(10), .RPT_CYC(4),
    .DEB_CYC(2), .BLINK_CYC(4)) keypad_jog_and_parameter_editor_i (
    .clk_i(clk_i), .srst_i(srst_i), .keys_i(keys_i), .status_bits_i(status_bits_i), .dummy_unused_o(),
    .motor_o(motor_o), .view_o(view_o), .status_bits_o(status_bits_o),
    .jog_speed_setting_o(jog_speed_setting_o), .save_pulse_o(save_pulse_o));

  // ==========================================================
  // Checking
  function automatic logic [16:0] seen(input int id);
    case (id)
      0: return {14'h0, view_o.mode};
      1: return {5'h0, view_o.number};
      2: return view_o.value;
      3: return {14'h0, view_o.digit};
      4: return {16'h0, motor_o.energize};
      5: return {16'h0, motor_o.fwd};
      6: return {16'h0, motor_o.rev};
      7: return motor_o.speed;
      default: return jog_speed_setting_o;
    endcase
  endfunction : seen

  task automatic note(input int id, input logic [16:0] v);
    exp_q.push_back('{id, v});
    -> chk_ev;
  endtask : note

  initial forever
  begin
    @chk_ev;
    while (exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      `CHK(nm[n.id], n.val, seen(n.id))
    end
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // Stimulus
  task automatic press(input int k, input int cyc);
    want[k] = 1'b1;
    repeat (cyc) @(negedge clk_i);
    want[k] = 1'b0;
    repeat (10) @(negedge clk_i);
  endtask : press

  task automatic long_data();
    press(0, L + 8 + int'($urandom % 8));
  endtask : long_data

  always @(negedge clk_i) status_bits_i <= 2'($urandom);

  initial
  begin
    #200000;
    err_count++;
    test_done();
  end

  initial
  begin
    void'($urandom(59702));
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    note(0, MODE_STATUS);
    note(3, 17'h00000);
    note(4, 17'h00000);
    note(8, 17'h001F4);
    $display("test reset done");
    press(1, 6);
    note(0, MODE_SYSCHK);
    press(4, 6);
    press(4, 6);
    note(1, 17'h00002);
    long_data();
    note(0, MODE_JOG);
    press(1, 6);
    note(4, 17'h00001);
    for (int k = 4; k >= 3; k--)
    begin
      want[k] = 1'b1;
      repeat (12) @(negedge clk_i);
      note(k == 4 ? 5 : 6, 17'h00001);
      note(7, 17'h001F4);
      press(k, 1);
      note(k == 4 ? 5 : 6, 17'h00000);
    end
    long_data();
    note(0, MODE_SYSCHK);
    note(4, 17'h00000);
    $display("test jog done");
    press(1, 6);
    note(0, MODE_PNUM);
    for (int i = 1; i <= 3; i++)
    begin
      press(0, 6);
      note(3, 17'(i % 3));
    end
    press(0, 6);
    press(4, 6);
    note(1, 17'h00010);
    press(0, 6);
    press(0, 6);
    repeat (6) press(4, 6);
    note(1, 17'h00100);
    press(0, 6);
    press(0, 6);
    press(4, 6);
    press(4, 6);
    press(0, 6);
    repeat (4) press(4, 6);
    note(1, 17'h00304);
    long_data();
    note(0, MODE_PSET);
    note(2, 17'h001F4);
    for (int i = 1; i <= 5; i++)
    begin
      press(0, 6);
      note(3, 17'(i % 5));
    end
    press(4, 6);
    note(2, 17'h001F5);
    press(3, 6);
    note(2, 17'h001F4);
    press(4, 6);
    press(4, 33);
    note(2, 17'h001FB);
    long_data();
    note(8, 17'h001FB);
    note(0, MODE_PSET);
    repeat (25) @(negedge clk_i);
    long_data();
    note(0, MODE_PNUM);
    press(2, 6);
    note(3, 17'h00002);
    press(1, 6);
    note(0, MODE_MON);
    press(1, 6);
    note(0, MODE_STATUS);
    $display("test editor done");
    srst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    note(0, MODE_STATUS);
    @(negedge clk_i);
    $display("test second reset done");
    test_done();
  end
endmodule : keypad_jog_and_parameter_editor_test
